// >>> inc/nabd_pkg.sv
// Constants, field positions and types shared by the nibble ALU and branch decoder
package nabd_pkg;

  // Clock and machine cycle timing
  localparam int CLK_HZ            = 20_000_000;
  localparam int CLK_PERIOD_NS     = 50;
  // One machine cycle lasts this many oscillator periods
  localparam int MC_OSC_PERIODS    = 4;
  // The core clock is the oscillator, so the count follows directly
  localparam int MC_CYCLES         = MC_OSC_PERIODS * (CLK_HZ / CLK_HZ);

  // Data path widths
  localparam int NIB_W             = 4;
  localparam int PC_W              = 14;
  localparam int PC_LOW_W          = 11;
  localparam int PAGE_W            = 3;
  localparam int BANK_W            = 3;
  localparam int RAM_AW            = 8;
  localparam int WR_AW             = 4;
  localparam int BUS_AW            = 9;
  localparam int BUS_DW            = 16;

  // Address forming: operand page times 10H, far jump bank times 800H
  localparam int PAGE_SHIFT        = 4;
  localparam int BANK_SHIFT        = 11;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
  localparam logic [PC_W-1:0] PC_SKIP = 14'h0002;

  // Register offsets on the plain register port
  localparam logic [BUS_AW-1:0] REG_CTRL  = 9'h000;
  localparam logic [BUS_AW-1:0] REG_FLAGS = 9'h001;
  localparam logic [BUS_AW-1:0] REG_ACC   = 9'h002;
  localparam logic [BUS_AW-1:0] REG_PAGE  = 9'h003;
  localparam logic [BUS_AW-1:0] REG_BANK  = 9'h004;
  localparam logic [BUS_AW-1:0] REG_PC    = 9'h005;
  localparam logic [BUS_AW-1:0] REG_LAST  = 9'h006;
  localparam logic [BUS_AW-1:0] WR_BASE   = 9'h010;
  localparam logic [BUS_AW-1:0] WR_LAST   = 9'h01F;
  localparam logic [BUS_AW-1:0] RAM_BASE  = 9'h100;

  // Field positions
  localparam int CTRL_RUN_BIT      = 0;
  localparam int FLAG_CARRY_BIT    = 0;
  localparam int FLAG_ZERO_BIT     = 1;

  // Reset values
  localparam logic [PC_W-1:0]   RST_PC    = 14'h0000;
  localparam logic [NIB_W-1:0]  RST_NIB   = 4'h0;
  localparam logic [PAGE_W-1:0] RST_PAGE  = 3'h0;
  localparam logic [BANK_W-1:0] RST_BANK  = 3'h0;
  localparam logic [15:0]       RST_INSTR = 16'h0000;

  // Operations of the nibble ALU
  typedef enum logic [2:0] {
    NABD_ADD,
    NABD_SUB,
    NABD_AND,
    NABD_OR,
    NABD_XOR
  } nabd_alu_op_t;

endpackage : nabd_pkg

// >>> inc/nabd_alu_if.sv
// Operand and result bundle between the decoder and the nibble ALU
`timescale 1ns/10ps
interface nabd_alu_if;
  import nabd_pkg::*;
  nabd_alu_op_t     op;
  logic [NIB_W-1:0] a;
  logic [NIB_W-1:0] b;
  logic             cin;
  logic [NIB_W-1:0] res;
  logic             cout;
  logic             zout;

  modport req (output op, a, b, cin, input res, cout, zout);
  modport alu (input op, a, b, cin, output res, cout, zout);
endinterface : nabd_alu_if

// >>> rtl/nabd_alu.sv
// Combinational 4-bit ALU: add, subtract with borrow, and, or, xor
`timescale 1ns/10ps
module nabd_alu
  import nabd_pkg::*;
(
  nabd_alu_if.alu port_if
);

  logic [NIB_W:0] wide;

  // Carry out is bit 4; on subtraction it is set when a borrow occurs
  always_comb begin
    wide = '0;
    case (port_if.op)
      NABD_ADD: wide = 5'(port_if.a) + 5'(port_if.b) + 5'(port_if.cin);
      NABD_SUB: wide = 5'(port_if.a) - 5'(port_if.b) - 5'(port_if.cin);
      NABD_AND: wide = {1'b0, port_if.a & port_if.b};
      NABD_OR:  wide = {1'b0, port_if.a | port_if.b};
      NABD_XOR: wide = {1'b0, port_if.a ^ port_if.b};
      default:  wide = '0;
    endcase
  end

  assign port_if.res  = wide[NIB_W-1:0];
  assign port_if.cout = wide[NIB_W];
  assign port_if.zout = (wide[NIB_W-1:0] == RST_NIB);

endmodule : nabd_alu

// >>> rtl/nabd_mcycle.sv
// Machine cycle divider: one execute pulse every MC_CYCLES clocks while running
`timescale 1ns/10ps
module nabd_mcycle
  import nabd_pkg::*;
#(
  parameter int CYCLES = MC_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Control
  input  wire logic run_i,
  // Execute strobe, one clock long
  output logic      step_o
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] phase_q;

  // Phase counter restarts while halted so each run begins a full cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= '0;
    end else if (!run_i) begin
      phase_q <= '0;
    end else if (phase_q == LAST) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + CW'(1);
    end
  end

  assign step_o = run_i && (phase_q == LAST);

endmodule : nabd_mcycle

// >>> rtl/nabd_core.sv
// Arithmetic, logic, branch and skip execution unit of a 4-bit core
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - Add forms: carry use and flag updates
// - Immediate add-carry writes register and accumulator
// - Subtract-borrow: nibble minus accumulator minus carry
// - Immediate subtract-borrow writes register and accumulator
// - Or write-back; logic ops touch zero only
// - Accumulator bit jump loads low eleven bits
// - Zero and nonzero accumulator jumps
// - Carry and no-carry jumps, flags kept
// - Decrement, write back, skip when zero
// - Decrement, write back, skip when nonzero
// - Memory bit test skips when set
// - Operand address is page times 10H plus field
module nabd_core
  import nabd_pkg::*;
#(
  parameter int MCYC = MC_CYCLES
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // Program word for the current program counter
  input  wire logic [15:0]       instr_i,
  // Register port
  input  wire logic [BUS_AW-1:0] addr_i,
  input  wire logic [BUS_DW-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [BUS_DW-1:0] rdata_o,
  // Core state
  output logic      [PC_W-1:0]   pc_o,
  output logic      [NIB_W-1:0]  main_operand_reg_o,
  output logic                   carry_bit_o,
  output logic                   zero_bit_o,
  output logic                   step_o
);

  // Architectural state
  logic [PC_W-1:0]   pc_q;
  logic [NIB_W-1:0]  acc_q;
  logic              carry_q;
  logic              zero_q;
  logic [PAGE_W-1:0] page_q;
  logic [BANK_W-1:0] program_bank_select_q;
  logic              run_q;
  logic [15:0]       last_q;
  logic [BUS_DW-1:0] rdata_q;
  logic              step_q;
  logic [NIB_W-1:0]  scratch_reg_n_q [2**WR_AW];
  logic [NIB_W-1:0]  ram_q           [2**RAM_AW];

  // Decoded instruction fields
  logic [3:0]          op_hi;
  logic                ext;
  logic [NIB_W-1:0]    imm;
  logic [WR_AW-1:0]    wr_sel;
  logic [6:0]          r_field;
  logic [PC_LOW_W-1:0] target;
  logic [RAM_AW-1:0]   ram_addr;
  logic [NIB_W-1:0]    ram_rd;
  logic [NIB_W-1:0]    wr_rd;

  // Execute controls
  logic            step;
  logic            do_acc;
  logic            do_ram;
  logic            do_wr;
  logic            do_c;
  logic            do_z;
  logic [PC_W-1:0] pc_d;

  // Bus decode
  logic            bus_wr_ram;
  logic            bus_wr_wr;

  nabd_alu_if alu_if ();

  nabd_alu u_alu (
    .port_if (alu_if)
  );

  // Execute strobe once per machine cycle
  nabd_mcycle #(
    .CYCLES (MCYC)
  ) u_mcycle (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (run_q),
    .step_o   (step)
  );

  // Field extraction from the single program word
  assign op_hi   = instr_i[15:12];
  assign ext     = instr_i[11];
  assign imm     = instr_i[7:4];
  assign wr_sel  = instr_i[3:0];
  assign r_field = instr_i[6:0];
  assign target  = instr_i[PC_LOW_W-1:0];

  // Direct operand address; overlapping pages alias by design
  assign ram_addr = (RAM_AW'(page_q) << PAGE_SHIFT) + RAM_AW'(r_field);
  assign ram_rd   = ram_q[ram_addr];
  assign wr_rd    = scratch_reg_n_q[wr_sel];

  // Main decoder: operands, write targets, flag updates and next PC
  always_comb begin
    alu_if.op  = NABD_ADD;
    alu_if.a   = ram_rd;
    alu_if.b   = acc_q;
    alu_if.cin = 1'b0;
    do_acc     = 1'b0;
    do_ram     = 1'b0;
    do_wr      = 1'b0;
    do_c       = 1'b0;
    do_z       = 1'b0;
    pc_d       = pc_q + PC_STEP;
    if (ext && (op_hi <= 4'h3) && (instr_i[10] || !instr_i[7])) begin
      // Immediate forms take a scratch register and the immediate
      if (instr_i[10]) begin
        alu_if.a = wr_rd;
        alu_if.b = imm;
      end
      do_acc = 1'b1;
      do_z   = 1'b1;
      do_ram = instr_i[8] && !instr_i[10];
      do_wr  = instr_i[8] && instr_i[10];
      case ({op_hi[1:0], instr_i[9]})
        3'b000: begin
          alu_if.op  = NABD_ADD;
          alu_if.cin = carry_q;
          do_c       = 1'b1;
        end
        3'b001: begin
          alu_if.op  = NABD_SUB;
          alu_if.cin = carry_q;
          do_c       = 1'b1;
        end
        3'b010: begin
          alu_if.op = NABD_ADD;
          do_c      = 1'b1;
        end
        3'b011: begin
          alu_if.op = NABD_SUB;
          do_c      = 1'b1;
        end
        3'b100: begin
          alu_if.op = NABD_ADD; // Unsigned add keeps carry
        end
        3'b101: begin
          alu_if.op = NABD_AND;
        end
        3'b110: begin
          alu_if.op = NABD_XOR;
        end
        default: begin
          alu_if.op = NABD_OR;
        end
      endcase
    end else if ((op_hi == 4'h4) && (instr_i[11:8] == 4'hA)) begin
      // Increment and decrement; the 1011 neighbour is a port read and must stay a no-op
      alu_if.op = instr_i[7] ? NABD_SUB : NABD_ADD;
      alu_if.b  = 4'h1;
      do_acc    = 1'b1;
      do_ram    = 1'b1;
      do_c      = 1'b1;
      do_z      = 1'b1;
    end else if ((op_hi == 4'h4) && (instr_i[11:8] == 4'h8)) begin
      // Decrement, write back, then skip on the result
      alu_if.op = NABD_SUB;
      alu_if.b  = 4'h1;
      do_acc    = 1'b1;
      do_ram    = 1'b1;
      do_c      = 1'b1;
      do_z      = 1'b1;
      if (alu_if.zout != instr_i[7]) begin
        pc_d = pc_q + PC_SKIP;
      end
    end else if ((op_hi == 4'hA) && (instr_i[11:9] == 3'b100)) begin
      // Bit test of a memory nibble, no flag touched
      if (ram_rd[{instr_i[8], instr_i[7]}]) begin
        pc_d = pc_q + PC_SKIP;
      end
    end else if (!ext) begin
      // Branch group: only the low eleven bits move, except far jump
      case (op_hi)
        4'h7: begin
          pc_d = (PC_W'(program_bank_select_q) << BANK_SHIFT) + PC_W'(target);
        end
        4'h8, 4'h9, 4'hA, 4'hB: begin
          if (acc_q[op_hi[1:0]]) begin
            pc_d = {pc_q[PC_W-1:PC_LOW_W], target};
          end
        end
        4'hE: begin
          if (acc_q == RST_NIB) begin
            pc_d = {pc_q[PC_W-1:PC_LOW_W], target};
          end
        end
        4'hC: begin
          if (acc_q != RST_NIB) begin
            pc_d = {pc_q[PC_W-1:PC_LOW_W], target};
          end
        end
        4'hF: begin
          if (carry_q) begin
            pc_d = {pc_q[PC_W-1:PC_LOW_W], target};
          end
        end
        4'hD: begin
          if (!carry_q) begin
            pc_d = {pc_q[PC_W-1:PC_LOW_W], target};
          end
        end
        default: begin
          pc_d = pc_q + PC_STEP;
        end
      endcase
    end
  end

  // Register port decode for the arrays
  assign bus_wr_ram = wr_i && (addr_i >= RAM_BASE);
  assign bus_wr_wr  = wr_i && (addr_i >= WR_BASE) && (addr_i <= WR_LAST);

  // Run control; software starts and stops the core
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 1'b0;
    end else if (wr_i && (addr_i == REG_CTRL)) begin
      run_q <= wdata_i[CTRL_RUN_BIT];
    end
  end

  // Program counter: execute wins over a software write in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q <= RST_PC;
    end else if (step) begin
      pc_q <= pc_d;
    end else if (wr_i && (addr_i == REG_PC)) begin
      pc_q <= wdata_i[PC_W-1:0];
    end
  end

  // Accumulator
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= RST_NIB;
    end else if (step && do_acc) begin
      acc_q <= alu_if.res;
    end else if (wr_i && (addr_i == REG_ACC)) begin
      acc_q <= wdata_i[NIB_W-1:0];
    end
  end

  // Flags: each updates only when its instruction group says so
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end else if (step) begin
      if (do_c) begin
        carry_q <= alu_if.cout;
      end
      if (do_z) begin
        zero_q <= alu_if.zout;
      end
    end else if (wr_i && (addr_i == REG_FLAGS)) begin
      carry_q <= wdata_i[FLAG_CARRY_BIT];
      zero_q  <= wdata_i[FLAG_ZERO_BIT];
    end
  end

  // Page and bank selects are set by software only in this block
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_q                <= RST_PAGE;
      program_bank_select_q <= RST_BANK;
    end else if (wr_i && (addr_i == REG_PAGE)) begin
      page_q <= wdata_i[PAGE_W-1:0];
    end else if (wr_i && (addr_i == REG_BANK)) begin
      program_bank_select_q <= wdata_i[BANK_W-1:0];
    end
  end

  // Scratch registers; write-back results win over software
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 2**WR_AW; i++) begin
        scratch_reg_n_q[i] <= RST_NIB;
      end
    end else if (step && do_wr) begin
      scratch_reg_n_q[wr_sel] <= alu_if.res;
    end else if (bus_wr_wr) begin
      scratch_reg_n_q[addr_i[WR_AW-1:0]] <= wdata_i[NIB_W-1:0];
    end
  end

  // Data memory; not reset, software loads it before running
  always_ff @(posedge clk_i) begin
    if (step && do_ram) begin
      ram_q[ram_addr] <= alu_if.res;
    end else if (bus_wr_ram) begin
      ram_q[addr_i[RAM_AW-1:0]] <= wdata_i[NIB_W-1:0];
    end
  end

  // Last executed word, kept for software tracing
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= RST_INSTR;
      step_q <= 1'b0;
    end else begin
      step_q <= step;
      if (step) begin
        last_q <= instr_i;
      end
    end
  end

  // Read data stand one cycle after the strobe, and only then
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= '0;
    end else if (!rd_i) begin
      rdata_q <= '0;
    end else if (addr_i == REG_CTRL) begin
      rdata_q <= BUS_DW'(run_q);
    end else if (addr_i == REG_FLAGS) begin
      rdata_q <= BUS_DW'({zero_q, carry_q});
    end else if (addr_i == REG_ACC) begin
      rdata_q <= BUS_DW'(acc_q);
    end else if (addr_i == REG_PAGE) begin
      rdata_q <= BUS_DW'(page_q);
    end else if (addr_i == REG_BANK) begin
      rdata_q <= BUS_DW'(program_bank_select_q);
    end else if (addr_i == REG_PC) begin
      rdata_q <= BUS_DW'(pc_q);
    end else if (addr_i == REG_LAST) begin
      rdata_q <= last_q;
    end else if ((addr_i >= WR_BASE) && (addr_i <= WR_LAST)) begin
      rdata_q <= BUS_DW'(scratch_reg_n_q[addr_i[WR_AW-1:0]]);
    end else if (addr_i >= RAM_BASE) begin
      rdata_q <= BUS_DW'(ram_q[addr_i[RAM_AW-1:0]]);
    end else begin
      rdata_q <= '0; // Unmapped offsets read as zero
    end
  end

  // Outputs come straight from flip-flops
  assign rdata_o            = rdata_q;
  assign pc_o               = pc_q;
  assign main_operand_reg_o = acc_q;
  assign carry_bit_o        = carry_q;
  assign zero_bit_o         = zero_q;
  assign step_o             = step_q;

endmodule : nabd_core

// >>> bench/nabd_core_sva.sv
// Port-level checker for the nibble execution core
`timescale 1ns/10ps
module nabd_core_sva
  import nabd_pkg::*;
#(
  parameter int MCYC = MC_CYCLES
)
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // Inputs
  input wire logic [15:0]       instr_i,
  input wire logic [BUS_AW-1:0] addr_i,
  input wire logic [BUS_DW-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  // Outputs
  input wire logic [BUS_DW-1:0] rdata_o,
  input wire logic [PC_W-1:0]   pc_o,
  input wire logic [NIB_W-1:0]  main_operand_reg_o,
  input wire logic              carry_bit_o,
  input wire logic              zero_bit_o,
  input wire logic              step_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [15:0]      instr_q;
  logic [PC_W-1:0]  pc_q;
  logic [NIB_W-1:0] acc_q;
  logic             c_q;
  logic             z_q;
  logic [PC_W-1:0]  tgt;
  logic [PC_W-1:0]  nxt;

  // State seen at the execute edge, so step_o cycles can compare old and new
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {instr_q, pc_q, acc_q, c_q, z_q} <= '0;
    end else begin
      {instr_q, pc_q, acc_q, c_q, z_q} <= {instr_i, pc_o, main_operand_reg_o, carry_bit_o,
                                           zero_bit_o};
    end
  end

  // Taken target keeps the 2K page bits; not taken moves one word
  assign tgt = {pc_q[13:11], instr_q[10:0]};
  assign nxt = pc_q + PC_STEP;

  AST_STEP_GAP: assert property (step_o |=> !step_o [*3])
    else $error("execute pulses closer than one machine cycle");
  AST_PC_CAUSE: assert property ((pc_o != pc_q) && !$past(wr_i) |-> step_o)
    else $error("pc moved without an instruction");
  AST_LOGIC_CARRY: assert property (step_o && (instr_q[15:11] == 5'b00111
    || (instr_q[15:11] == 5'b00101 && instr_q[9]))
    && (instr_q[10] || !instr_q[7]) |-> carry_bit_o == c_q
    && zero_bit_o == (main_operand_reg_o == 4'h0)) else $error("logic op flags wrong");
  AST_ACC_BIT_JUMP: assert property (step_o && instr_q[15:14] == 2'b10 && !instr_q[11]
    |-> pc_o == (acc_q[instr_q[13:12]] ? tgt : nxt) && carry_bit_o == c_q)
    else $error("accumulator bit jump wrong");
  AST_ZERO_JUMP: assert property (step_o && instr_q[15:14] == 2'b11 && instr_q[12:11] == 2'b00
    |-> pc_o == (((acc_q == 4'h0) == instr_q[13]) ? tgt : nxt))
    else $error("zero jump wrong");
  AST_CARRY_JUMP: assert property (step_o && instr_q[15:14] == 2'b11 && instr_q[12:11] == 2'b10
    |-> pc_o == ((c_q == instr_q[13]) ? tgt : nxt) && zero_bit_o == z_q)
    else $error("carry jump wrong");
  AST_FAR_JUMP: assert property (step_o && instr_q[15:11] == 5'b01110
    |-> pc_o[10:0] == instr_q[10:0] && main_operand_reg_o == acc_q)
    else $error("far jump wrong");
  AST_DEC_SKIP: assert property (step_o && instr_q[15:8] == 8'h48
    |-> pc_o == (((main_operand_reg_o == 4'h0) != instr_q[7]) ? pc_q + PC_SKIP : nxt)
    && carry_bit_o == (main_operand_reg_o == 4'hF)) else $error("decrement skip wrong");
endmodule : nabd_core_sva

bind nabd_core nabd_core_sva #(.MCYC(MCYC)) u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .instr_i(instr_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pc_o(pc_o), .main_operand_reg_o(main_operand_reg_o),
  .carry_bit_o(carry_bit_o), .zero_bit_o(zero_bit_o), .step_o(step_o));

// >>> bench/nibble_alu_branch_decoder_test.sv
// Self-checking bench for the nibble execution core
`timescale 1ns/10ps
module nibble_alu_branch_decoder_test;
  import nabd_pkg::*;
  localparam int MCYC = 4;
  localparam logic [PC_W-1:0]   PC0   = 14'h2345;
  localparam logic [PC_W-1:0]   PCN   = 14'h2346;
  localparam logic [PC_W-1:0]   PCS   = 14'h2347;
  localparam logic [PC_W-1:0]   PCT   = 14'h25A5;
  localparam logic [10:0]       TGT   = 11'h5A5;
  localparam logic [BUS_AW-1:0] RAM_X = 9'h115; // Page 1, field 05H

  logic clk_i, arst_n_i, wr_i, rd_i, carry_bit_o, zero_bit_o, step_o;
  logic [15:0]       instr_i;
  logic [BUS_AW-1:0] addr_i;
  logic [BUS_DW-1:0] wdata_i, rdata_o;
  logic [PC_W-1:0]   pc_o;
  logic [NIB_W-1:0]  main_operand_reg_o;
  int err_total;
  int checks;

  nabd_core #(.MCYC(MCYC)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pc_o(pc_o), .main_operand_reg_o(main_operand_reg_o), .carry_bit_o(carry_bit_o),
    .zero_bit_o(zero_bit_o), .step_o(step_o));

  // Clock
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [BUS_AW-1:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    check(name, exp, rdata_o);
  endtask : rd_chk

  // Run exactly one instruction, then stop so the pc cannot run on
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    instr_i <= w;
    wr_reg(REG_CTRL, 16'h0001);
    while (step_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check("step delay", 16'(MCYC + 1), 16'(n));
    wr_reg(REG_CTRL, 16'h0000);
    @(negedge clk_i);
  endtask : exec

  // Flags given as {zero, carry}; pc always starts at PC0
  task automatic run_op(input logic [15:0] w, input logic [3:0] ram, input logic [3:0] acc,
                        input logic [1:0] flg, input logic [3:0] eacc, input logic [1:0] eflg,
                        input logic [PC_W-1:0] epc);
    wr_reg(RAM_X, {12'h000, ram});
    wr_reg(REG_ACC, {12'h000, acc});
    wr_reg(REG_FLAGS, {14'h0000, flg});
    wr_reg(REG_PC, {2'b00, PC0});
    exec(w);
    check("acc", {12'h000, eacc}, {12'h000, main_operand_reg_o});
    check("flags", {14'h0000, eflg}, {14'h0000, zero_bit_o, carry_bit_o});
    check("pc", {2'b00, epc}, {2'b00, pc_o});
  endtask : run_op

  task automatic t_reset();
    check("reset state", 16'h0000, {pc_o, zero_bit_o, carry_bit_o});
    check("reset acc", 16'h0000, {11'h000, step_o, main_operand_reg_o});
    check("reset rdata", 16'h0000, rdata_o);
    wr_reg(9'h008, 16'h000F);
    rd_chk("unmapped", 9'h008, 16'h0000);
  endtask : t_reset

  task automatic t_arith();
    wr_reg(REG_PAGE, 16'h0001);
    run_op(16'h0805, 4'h7, 4'h8, 2'b01, 4'h0, 2'b11, PCN);
    run_op(16'h1805, 4'h7, 4'h8, 2'b01, 4'hF, 2'b00, PCN);
    run_op(16'h2805, 4'h7, 4'h9, 2'b00, 4'h0, 2'b10, PCN);
    run_op(16'h0A05, 4'h7, 4'h3, 2'b01, 4'h3, 2'b00, PCN);
    run_op(16'h0A05, 4'h7, 4'h8, 2'b00, 4'hF, 2'b01, PCN);
    run_op(16'h1A05, 4'h7, 4'h8, 2'b01, 4'hF, 2'b01, PCN);
    wr_reg(WR_BASE + 9'h003, 16'h000C);
    run_op(16'h0D53, 4'h0, 4'h0, 2'b01, 4'h2, 2'b01, PCN);
    rd_chk("scratch", WR_BASE + 9'h003, 16'h0002);
    run_op(16'h0F43, 4'h0, 4'h0, 2'b01, 4'hD, 2'b01, PCN);
    rd_chk("scratch", WR_BASE + 9'h003, 16'h000D);
  endtask : t_arith

  task automatic t_logic_skip();
    run_op(16'h3B05, 4'h7, 4'h8, 2'b01, 4'hF, 2'b01, PCN);
    rd_chk("ram or", RAM_X, 16'h000F);
    run_op(16'h3A05, 4'h0, 4'h0, 2'b01, 4'h0, 2'b11, PCN);
    run_op(16'h2A05, 4'h7, 4'h8, 2'b01, 4'h0, 2'b11, PCN);
    run_op(16'h3805, 4'h7, 4'h8, 2'b01, 4'hF, 2'b01, PCN);
    run_op(16'h4A05, 4'hF, 4'h3, 2'b00, 4'h0, 2'b11, PCN);
    run_op(16'h4B05, 4'h7, 4'h3, 2'b10, 4'h3, 2'b10, PCN);
    run_op(16'h4805, 4'h1, 4'h9, 2'b00, 4'h0, 2'b10, PCS);
    run_op(16'h4805, 4'h0, 4'h9, 2'b00, 4'hF, 2'b01, PCN);
    rd_chk("ram dec", RAM_X, 16'h000F);
    run_op(16'h4885, 4'h0, 4'h9, 2'b10, 4'hF, 2'b01, PCS);
    run_op(16'h4885, 4'h1, 4'h9, 2'b00, 4'h0, 2'b10, PCN);
    for (int b = 0; b < 4; b++) begin
      run_op(16'hA805 | 16'(b << 7), 4'h5, 4'h6, 2'b11, 4'h6, 2'b11, b[0] ? PCN : PCS);
    end
  endtask : t_logic_skip

  task automatic t_branch();
    for (int b = 0; b < 4; b++) begin
      run_op({4'(8 + b), 1'b0, TGT}, 4'h0, 4'h5, 2'b01, 4'h5, 2'b01, b[0] ? PCN : PCT);
    end
    for (int a = 0; a < 2; a++) begin
      run_op({5'b11100, TGT}, 4'h0, 4'(a), 2'b00, 4'(a), 2'b00, a ? PCN : PCT);
      run_op({5'b11000, TGT}, 4'h0, 4'(a), 2'b11, 4'(a), 2'b11, a ? PCT : PCN);
      run_op({5'b11110, TGT}, 4'h0, 4'h3, 2'(a), 4'h3, 2'(a), a ? PCT : PCN);
      run_op({5'b11010, TGT}, 4'h0, 4'h3, 2'(a), 4'h3, 2'(a), a ? PCN : PCT);
    end
    wr_reg(REG_BANK, 16'h0005);
    run_op({5'b01110, TGT}, 4'h0, 4'h3, 2'b11, 4'h3, 2'b11, 14'h2DA5);
  endtask : t_branch

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence; inputs valued at time zero, reset held five cycles
  initial begin
    {err_total, checks} = '0;
    {clk_i, arst_n_i, wr_i, rd_i, instr_i, addr_i, wdata_i} = '0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_arith();
    t_logic_skip();
    t_branch();
    report_and_stop();
  end

  // About 35 ops of some 16 cycles each; generous margin before calling it hung
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule : nibble_alu_branch_decoder_test
